/* File: hw/operand_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
module operand_shifter
(
  input  wire shift_psr_pkg::shift_req_s req,
  output var  shift_psr_pkg::shift_res_s res
);

  logic [7:0]         amt;
  logic               rotate_extended_carry;
  logic [32:0]        lsl_w;
  logic [32:0]        lsr_w;
  logic signed [32:0] asr_w;
  logic [4:0]         rot;
  logic [31:0]        ror_v;

  // encoded zero on right shifts stands for 32, on rotate for rrx
  always_comb
  begin
    amt = req.amount;
    rotate_extended_carry = 1'b0;
    if (req.imm_form && req.amount == 8'h00)
    begin
      if (req.kind == shift_psr_pkg::rotate_right)
        rotate_extended_carry = 1'b1;
      else if (req.kind != shift_psr_pkg::shift_left_logical)
        amt = shift_psr_pkg::SHIFT_FULL;
    end
  end

  // one extra bit carries the last bit shifted out
  always_comb
  begin
    lsl_w = {1'b0, req.operand} << amt;
    lsr_w = {req.operand, 1'b0} >> amt;
    asr_w = $signed({req.operand, 1'b0}) >>> ((amt > shift_psr_pkg::SHIFT_FULL) ? shift_psr_pkg::SHIFT_FULL : amt);
    rot   = amt[4:0];  // any multiple of 32 folds onto a whole turn
    ror_v = (req.operand >> rot) | (req.operand << (shift_psr_pkg::ROT_SPAN - {1'b0, rot}));
  end

  // pick the result; rrx wins, otherwise zero amount passes operand and old carry
  always_comb
  begin
    res.result = req.operand;
    res.carry  = req.carry_in;
    if (rotate_extended_carry)
    begin
      res.result = {req.carry_in, req.operand[31:1]};
      res.carry  = req.operand[0];
    end
    else if (amt != 8'h00)
    begin
      case (req.kind)
        shift_psr_pkg::shift_left_logical:
        begin
          res.result = lsl_w[31:0];
          res.carry  = lsl_w[32];
        end
        shift_psr_pkg::shift_right_logical:
        begin
          res.result = lsr_w[32:1];
          res.carry  = lsr_w[0];
        end
        shift_psr_pkg::shift_right_arith:
        begin
          res.result = asr_w[32:1];
          res.carry  = asr_w[0];
        end
        default:
        begin
          res.result = ror_v;
          res.carry  = ror_v[31];
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: hw/shift_psr_core.sv */
// Functional notes
// - lsl by encoded zero passes operand, old carry
// - encoded right shift zero means 32
// - arithmetic shift fills with sign bit
// - encoded arithmetic zero means 32, all sign
// - rotate wraps; encoded zero is rrx
// - register amount uses low byte; zero passes
// - register amounts 1-31 match encoded shifts
// - register lsl 32 gives bit 0 carry
// - register lsr 32 gives bit 31 carry
// - register asr 32 or more fills sign
// - register rotate folds modulo 32
// - register shift with bit 7 set undefined
// - immediate is 8 bits rotated by twice field
// - pc destination without s keeps status
// - pc destination with s restores saved word
// - pc operand is address plus 8 or 12
// - legacy test form restores saved when privileged
// - cycle cost by shift amount source and pc write
// - test opcodes without s are status moves
// - flags-only write touches top four bits
// - user mode writes only the flags
// - saved word chosen by current mode
// - logical ops with s load shifter carry
// - encoded shift amount is five bits
`timescale 1ns/1ps
`default_nettype none
module shift_psr_core
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  logic [31:0] instr;
  logic [31:0] m_val;
  logic [31:0] s_val;
  logic [31:0] instr_addr;
  logic [31:0] result;
  logic [31:0] operand2;
  logic [31:0] current_status_word;
  logic [31:0] pc;
  logic [31:0] pc_operand;
  logic [31:0] move_out;
  shift_psr_pkg::exec_info_s info;
  logic [31:0] saved_status_word [shift_psr_pkg::BANKS];

  logic        access;
  logic        wr;
  logic        exec;
  logic        mapped;
  logic [2:0]  bank;
  logic        bank_ok;
  logic [31:0] saved_cur;
  logic        imm_op;
  logic [3:0]  opcode;
  logic        sbit;
  logic        rd_pc;
  logic        reg_shift;
  logic        bad_bit7;
  logic        is_test;
  logic        psr_move;
  logic        to_status;
  logic        use_saved;
  logic        flags_only;
  logic        legacy;
  logic        logical;
  logic        writes_pc;
  logic        user;
  logic [31:0] m_src;
  logic [31:0] move_src;
  logic [31:0] next_current;
  logic [31:0] next_saved;
  logic        saved_we;
  shift_psr_pkg::shift_req_s  req;
  shift_psr_pkg::shift_res_s  res;
  shift_psr_pkg::exec_info_s  next_info;

  // apb strobes; pready is high in every access phase
  assign access = psel & penable & pready;
  assign wr     = access & pwrite;
  assign exec   = wr & (paddr == shift_psr_pkg::ADDR_EXEC);

  // map current mode onto its saved word bank
  always_comb
  begin
    bank_ok = 1'b1;
    case (current_status_word[shift_psr_pkg::MODE_MSB:0])
      shift_psr_pkg::MODE_FIQ: bank = 3'h0;
      shift_psr_pkg::MODE_IRQ: bank = 3'h1;
      shift_psr_pkg::MODE_SVC: bank = 3'h2;
      shift_psr_pkg::MODE_ABT: bank = 3'h3;
      shift_psr_pkg::MODE_UND: bank = 3'h4;
      default:
      begin
        bank    = 3'h0;
        bank_ok = 1'b0;  // user and system own no saved word
      end
    endcase
  end
  assign saved_cur = bank_ok ? saved_status_word[bank] : 32'h0000_0000;
  assign user      = current_status_word[shift_psr_pkg::MODE_MSB:0] == shift_psr_pkg::MODE_USER;

  // instruction decode
  assign imm_op     = instr[shift_psr_pkg::IMM_BIT];
  assign opcode     = instr[shift_psr_pkg::OPC_MSB:shift_psr_pkg::OPC_LSB];
  assign sbit       = instr[shift_psr_pkg::S_BIT];
  assign rd_pc      = instr[shift_psr_pkg::RD_MSB:shift_psr_pkg::RD_LSB] == shift_psr_pkg::PC_REG;
  assign reg_shift  = !imm_op & instr[shift_psr_pkg::REG_SHIFT];
  assign bad_bit7   = reg_shift & instr[shift_psr_pkg::BIT7];
  assign is_test    = opcode[3:2] == 2'h2;
  assign psr_move   = is_test & !sbit & !bad_bit7;
  assign to_status  = psr_move & opcode[0];
  assign use_saved  = instr[shift_psr_pkg::SAVED_SEL];
  assign flags_only = !instr[shift_psr_pkg::WHOLE_BIT];
  assign legacy     = opcode == shift_psr_pkg::OPC_TEQ && sbit && rd_pc && !bad_bit7;
  assign logical    = opcode[2:1] == 2'h0 || opcode[3:2] == 2'h3;
  assign writes_pc  = !is_test & rd_pc & !bad_bit7;

  // pc read as operand runs ahead of the instruction address
  assign m_src = (instr[shift_psr_pkg::RM_MSB:0] == shift_psr_pkg::PC_REG) ? pc_operand_now() : m_val;

  function automatic logic [31:0] pc_operand_now();
    pc_operand_now = instr_addr + (reg_shift ? shift_psr_pkg::PC_AHEAD_REG : shift_psr_pkg::PC_AHEAD_IMM);
  endfunction

  // shifter request: immediate rotate or shifted register
  always_comb
  begin
    req.carry_in = current_status_word[shift_psr_pkg::FLAG_C];
    if (imm_op)
    begin
      req.operand  = {24'h00_0000, instr[shift_psr_pkg::IMM8_MSB:0]};
      req.amount   = {3'h0, instr[shift_psr_pkg::ROT_MSB:shift_psr_pkg::ROT_LSB], 1'b0};
      req.kind     = shift_psr_pkg::rotate_right;
      req.imm_form = 1'b0;  // rotate of zero keeps carry, as it should
    end
    else
    begin
      req.operand  = m_src;
      req.amount   = reg_shift ? s_val[7:0] : {3'h0, instr[shift_psr_pkg::AMT_MSB:shift_psr_pkg::AMT_LSB]};
      req.kind     = shift_psr_pkg::shift_kind_e'(instr[shift_psr_pkg::KIND_MSB:shift_psr_pkg::KIND_LSB]);
      req.imm_form = !reg_shift;
    end
  end

  operand_shifter shifter
  (
    .req (req),
    .res (res)
  );

  // status move source: immediate goes through the rotator
  assign move_src = imm_op ? res.result : m_val;

  // next current status word; earlier branches take priority
  always_comb
  begin
    next_current = current_status_word;
    if (psr_move)
    begin
      if (to_status && !use_saved)
      begin
        if (flags_only || user)
          next_current[shift_psr_pkg::FLAG_N:shift_psr_pkg::FLAG_LSB] =
            move_src[shift_psr_pkg::FLAG_N:shift_psr_pkg::FLAG_LSB];
        else
          next_current = move_src;
      end
    end
    else if (legacy)
    begin
      if (!user && bank_ok)
        next_current = saved_cur;
    end
    else if (writes_pc)
    begin
      if (sbit && bank_ok)
        next_current = saved_cur;
    end
    else if (sbit && logical && !bad_bit7)
    begin
      next_current[shift_psr_pkg::FLAG_N] = result[shift_psr_pkg::FLAG_N];
      next_current[shift_psr_pkg::FLAG_Z] = result == 32'h0000_0000;
      next_current[shift_psr_pkg::FLAG_C] = res.carry;
    end
  end

  // saved word write for the active mode only
  always_comb
  begin
    saved_we   = to_status & use_saved & bank_ok;
    next_saved = saved_cur;
    if (flags_only)
      next_saved[shift_psr_pkg::FLAG_N:shift_psr_pkg::FLAG_LSB] =
        move_src[shift_psr_pkg::FLAG_N:shift_psr_pkg::FLAG_LSB];
    else
      next_saved = move_src;
  end

  // cycle cost and outcome flags
  always_comb
  begin
    next_info            = '0;
    next_info.carry      = res.carry;
    next_info.undefined  = bad_bit7;
    next_info.psr_moved  = psr_move;
    next_info.pc_written = writes_pc;
    if (!bad_bit7)
    begin
      next_info.seq      = writes_pc ? 2'h2 : 2'h1;
      next_info.nonseq   = writes_pc;
      next_info.internal = reg_shift;
    end
  end

  // software-loaded operand registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr      <= 32'h0000_0000;
      m_val      <= 32'h0000_0000;
      s_val      <= 32'h0000_0000;
      instr_addr <= 32'h0000_0000;
      result     <= 32'h0000_0000;
    end
    else if (wr)
    begin
      case (paddr)
        shift_psr_pkg::ADDR_INSTR:      instr      <= pwdata;
        shift_psr_pkg::ADDR_OPERAND_M:  m_val      <= pwdata;
        shift_psr_pkg::ADDR_OPERAND_S:  s_val      <= pwdata;
        shift_psr_pkg::ADDR_INSTR_ADDR: instr_addr <= pwdata;
        shift_psr_pkg::ADDR_RESULT:     result     <= pwdata;
        default: ;
      endcase
    end
  end

  // execution results captured on the execute strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      operand2   <= 32'h0000_0000;
      pc_operand <= 32'h0000_0000;
      move_out   <= 32'h0000_0000;
      info       <= '0;
      pc         <= 32'h0000_0000;
    end
    else if (exec)
    begin
      operand2   <= res.result;
      pc_operand <= pc_operand_now();
      info       <= next_info;
      if (psr_move && !to_status)
        move_out <= use_saved ? saved_cur : current_status_word;
      if (writes_pc)
        pc <= result;
    end
  end

  // current status word: execute or direct software load
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      current_status_word <= shift_psr_pkg::STATUS_RESET;
    else if (exec)
      current_status_word <= next_current;
    else if (wr && paddr == shift_psr_pkg::ADDR_CURRENT)
      current_status_word <= pwdata;
  end

  // one saved word per privileged mode except system
  for (genvar i = 0; i < shift_psr_pkg::BANKS; i++)
  begin : g_bank
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        saved_status_word[i] <= 32'h0000_0000;
      else if (bank_ok && bank == 3'(i))
      begin
        if (exec && saved_we)
          saved_status_word[i] <= next_saved;
        else if (wr && paddr == shift_psr_pkg::ADDR_SAVED)
          saved_status_word[i] <= pwdata;
      end
    end
  end

  // apb read path, registered in the setup phase
  always_comb
  begin
    mapped = 1'b1;
    case (paddr)
      shift_psr_pkg::ADDR_INSTR, shift_psr_pkg::ADDR_OPERAND_M, shift_psr_pkg::ADDR_OPERAND_S,
      shift_psr_pkg::ADDR_INSTR_ADDR, shift_psr_pkg::ADDR_RESULT, shift_psr_pkg::ADDR_EXEC,
      shift_psr_pkg::ADDR_OPERAND2, shift_psr_pkg::ADDR_INFO, shift_psr_pkg::ADDR_CURRENT,
      shift_psr_pkg::ADDR_SAVED, shift_psr_pkg::ADDR_PC, shift_psr_pkg::ADDR_PC_OPERAND,
      shift_psr_pkg::ADDR_MOVE_OUT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & !penable;
      pslverr <= psel & !penable & !mapped;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          shift_psr_pkg::ADDR_INSTR:      prdata <= instr;
          shift_psr_pkg::ADDR_OPERAND_M:  prdata <= m_val;
          shift_psr_pkg::ADDR_OPERAND_S:  prdata <= s_val;
          shift_psr_pkg::ADDR_INSTR_ADDR: prdata <= instr_addr;
          shift_psr_pkg::ADDR_RESULT:     prdata <= result;
          shift_psr_pkg::ADDR_OPERAND2:   prdata <= operand2;
          shift_psr_pkg::ADDR_INFO:       prdata <= {24'h00_0000, info};
          shift_psr_pkg::ADDR_CURRENT:    prdata <= current_status_word;
          shift_psr_pkg::ADDR_SAVED:      prdata <= saved_cur;
          shift_psr_pkg::ADDR_PC:         prdata <= pc;
          shift_psr_pkg::ADDR_PC_OPERAND: prdata <= pc_operand;
          shift_psr_pkg::ADDR_MOVE_OUT:   prdata <= move_out;
          default:                        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic enc_shift;
  assign enc_shift = exec & !imm_op & !reg_shift;
  sequence s_exec_pc(logic s);
    exec && writes_pc && sbit == s;
  endsequence

  a_lsl_zero_pass: assert property (enc_shift && instr[11:5] == 7'h00 |=>
    operand2 == $past(m_src) && info.carry == $past(current_status_word[shift_psr_pkg::FLAG_C]))
    else $error("lsl zero did not pass operand and carry");
  a_lsr_enc_full: assert property (enc_shift && instr[11:5] == 7'h01 |=>
    operand2 == 32'h0000_0000 && info.carry == $past(m_src[31]))
    else $error("encoded lsr zero is not a shift by 32");
  a_asr_enc_sign: assert property (enc_shift && instr[11:5] == 7'h02 |=>
    operand2 == {32{$past(m_src[31])}} && info.carry == $past(m_src[31]))
    else $error("encoded asr zero is not a sign fill");
  a_rrx_carry: assert property (enc_shift && instr[11:5] == 7'h03 |=>
    info.carry == $past(m_src[0]) && operand2[31] == $past(current_status_word[shift_psr_pkg::FLAG_C]))
    else $error("rrx carry wrong");
  a_reg_lsl_full: assert property (exec && reg_shift && !bad_bit7 && instr[6:5] == 2'h0
    && s_val[7:0] == 8'h20 |=> operand2 == 32'h0000_0000 && info.carry == $past(m_src[0]))
    else $error("register lsl 32 wrong");
  a_reg_ror_full: assert property (exec && reg_shift && instr[6:5] == 2'h3 && s_val[7:0] == 8'h40
    |=> operand2 == $past(m_src) && info.carry == $past(m_src[31]))
    else $error("register ror 64 wrong");
  a_pc_keep_status: assert property (s_exec_pc(1'b0) |=>
    pc == $past(result) && $stable(current_status_word))
    else $error("pc write without s changed status");
  a_pc_restore: assert property (s_exec_pc(1'b1) ##0 bank_ok |=>
    pc == $past(result) && current_status_word == $past(saved_cur))
    else $error("pc write with s did not restore status");
  a_pc_ahead: assert property (exec |=>
    pc_operand == $past(instr_addr) + ($past(reg_shift) ? 32'h0000_000c : 32'h0000_0008))
    else $error("pc operand offset wrong");
  a_cycle_cost: assert property (exec && !bad_bit7 |=>
    info.seq == ($past(writes_pc) ? 2'h2 : 2'h1) && info.internal == $past(reg_shift))
    else $error("cycle cost wrong");
  a_user_flags: assert property (exec && to_status && !use_saved && user |=>
    current_status_word[27:0] == $past(current_status_word[27:0]))
    else $error("user mode changed control bits");

endmodule
`default_nettype wire

/* File: hw/shift_psr_pkg.sv */
package shift_psr_pkg;

  // register byte offsets on the apb side
  localparam logic [7:0] ADDR_INSTR      = 8'h00;
  localparam logic [7:0] ADDR_OPERAND_M  = 8'h04;
  localparam logic [7:0] ADDR_OPERAND_S  = 8'h08;
  localparam logic [7:0] ADDR_INSTR_ADDR = 8'h0c;
  localparam logic [7:0] ADDR_RESULT     = 8'h10;
  localparam logic [7:0] ADDR_EXEC       = 8'h14;
  localparam logic [7:0] ADDR_OPERAND2   = 8'h18;
  localparam logic [7:0] ADDR_INFO       = 8'h1c;
  localparam logic [7:0] ADDR_CURRENT    = 8'h20;
  localparam logic [7:0] ADDR_SAVED      = 8'h24;
  localparam logic [7:0] ADDR_PC         = 8'h28;
  localparam logic [7:0] ADDR_PC_OPERAND = 8'h2c;
  localparam logic [7:0] ADDR_MOVE_OUT   = 8'h30;

  // instruction field positions
  localparam int IMM_BIT      = 25;
  localparam int OPC_MSB      = 24;
  localparam int OPC_LSB      = 21;
  localparam int SAVED_SEL    = 22;
  localparam int S_BIT        = 20;
  localparam int WHOLE_BIT    = 16;
  localparam int RD_MSB       = 15;
  localparam int RD_LSB       = 12;
  localparam int ROT_MSB      = 11;
  localparam int ROT_LSB      = 8;
  localparam int AMT_MSB      = 11;
  localparam int AMT_LSB      = 7;
  localparam int BIT7         = 7;
  localparam int KIND_MSB     = 6;
  localparam int KIND_LSB     = 5;
  localparam int REG_SHIFT    = 4;
  localparam int RM_MSB       = 3;
  localparam int IMM8_MSB     = 7;

  // status word layout
  localparam int FLAG_N       = 31;
  localparam int FLAG_Z       = 30;
  localparam int FLAG_C       = 29;
  localparam int FLAG_LSB     = 28;
  localparam int MODE_MSB     = 4;

  localparam logic [3:0]  PC_REG       = 4'hf;
  localparam logic [4:0]  MODE_USER    = 5'h10;
  localparam logic [4:0]  MODE_FIQ     = 5'h11;
  localparam logic [4:0]  MODE_IRQ     = 5'h12;
  localparam logic [4:0]  MODE_SVC     = 5'h13;
  localparam logic [4:0]  MODE_ABT     = 5'h17;
  localparam logic [4:0]  MODE_UND     = 5'h1b;
  localparam int          BANKS        = 5;
  localparam logic [31:0] STATUS_RESET = 32'h0000_00d3;
  localparam logic [31:0] PC_AHEAD_IMM = 32'h0000_0008;
  localparam logic [31:0] PC_AHEAD_REG = 32'h0000_000c;
  localparam logic [7:0]  SHIFT_FULL   = 8'h20;
  localparam logic [5:0]  ROT_SPAN     = 6'h20;
  localparam logic [3:0]  OPC_TEQ      = 4'h9;

  typedef enum logic [1:0] {
    shift_left_logical,
    shift_right_logical,
    shift_right_arith,
    rotate_right
  } shift_kind_e;

  typedef struct packed {
    logic [31:0] operand;
    logic [7:0]  amount;
    shift_kind_e kind;
    logic        imm_form;
    logic        carry_in;
  } shift_req_s;

  typedef struct packed {
    logic [31:0] result;
    logic        carry;
  } shift_res_s;

  typedef struct packed {
    logic [1:0] seq;
    logic       nonseq;
    logic       internal;
    logic       psr_moved;
    logic       pc_written;
    logic       undefined;
    logic       carry;
  } exec_info_s;

endpackage

/* File: tb/core_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_side_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer; request held until pready is seen at a rising edge, for up to 16 edges
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output logic ok);
    int n;
    ok = 1'b0;
    q = 32'h0;
    err = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16 && !ok; n++)
    begin
      // answer as it stands at the rising edge that completes the access
      @(posedge pclk);
      if (pready === 1'b1)
      begin
        ok = 1'b1;
        q = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // stale data is not left on the bus
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_barrel_shift_operand_psr.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_barrel_shift_operand_psr;
  localparam logic [31:0] MV   = 32'h8000_0009;
  localparam logic [31:0] BASE = 32'h01a0_1002;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] q;
  logic        e;
  logic        ok;
  int          fails;
  int          compares;

  shift_psr_core i_dut
  (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  core_side_model i_core
  (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // 100 MHz core clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask

  // a missing answer ends the run as a failure
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_core.xfer(w, a, d, q, e, ok);
    if (ok !== 1'b1)
    begin
      fails++;
      end_of_test();
    end
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] x);
    acc(1'b0, a, 32'h0);
    chk(nm, q, x);
  endtask

  task automatic cur(input logic [31:0] x);
    rc("current", shift_psr_pkg::ADDR_CURRENT, x);
  endtask

  task automatic sv(input logic [31:0] x);
    rc("saved", shift_psr_pkg::ADDR_SAVED, x);
  endtask

  task automatic wc(input logic [31:0] d);
    acc(1'b1, shift_psr_pkg::ADDR_CURRENT, d);
  endtask

  task automatic ex(input logic [31:0] i, input logic [31:0] m, input logic [31:0] s);
    acc(1'b1, shift_psr_pkg::ADDR_OPERAND_M, m);
    acc(1'b1, shift_psr_pkg::ADDR_OPERAND_S, s);
    acc(1'b1, shift_psr_pkg::ADDR_INSTR, i);
    acc(1'b1, shift_psr_pkg::ADDR_EXEC, 32'h0);
  endtask

  // result, carry and cost; a register amount adds one internal cycle
  task automatic sh(input logic [31:0] i, input logic [31:0] s, input logic [31:0] r, input logic c);
    logic rs;
    rs = i[4] & ~i[25];
    ex(i, MV, s);
    rc("operand2", shift_psr_pkg::ADDR_OPERAND2, r);
    acc(1'b0, shift_psr_pkg::ADDR_INFO, 32'h0);
    chk("info", q & 32'hff, {24'h0, 3'b010, rs, 3'b000, c});
    rc("pc operand", shift_psr_pkg::ADDR_PC_OPERAND, rs ? 32'h100c : 32'h1008);
  endtask

  initial
  begin
    presetn = 1'b0;
    fails = 0;
    compares = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    cur(32'h0000_00d3);
    acc(1'b0, 8'h3c, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    acc(1'b1, shift_psr_pkg::ADDR_INSTR_ADDR, 32'h1000);
    wc(32'h2000_00d3);
    sh(BASE, 0, MV, 1'b1);
    sh(BASE | 32'h20, 0, 0, 1'b1);
    sh(BASE | 32'h240, 0, 32'hf800_0000, 1'b1);
    sh(BASE | 32'h40, 0, 32'hffff_ffff, 1'b1);
    sh(BASE | 32'h60, 0, 32'hc000_0004, 1'b1);
    sh(BASE | 32'h260, 0, 32'h9800_0000, 1'b1);
    sh(BASE | 32'hf80, 0, 32'h8000_0000, 1'b0);
    sh(BASE | 32'h330, 32'h100, MV, 1'b1);
    sh(BASE | 32'h330, 32'hffff_ff04, 32'h0800_0000, 1'b1);
    sh(BASE | 32'h310, 32'h20, 0, 1'b1);
    sh(BASE | 32'h310, 32'h21, 0, 1'b0);
    sh(BASE | 32'h330, 32'h20, 0, 1'b1);
    sh(BASE | 32'h330, 32'h21, 0, 1'b0);
    sh(BASE | 32'h350, 32'hc8, 32'hffff_ffff, 1'b1);
    sh(BASE | 32'h370, 32'h20, MV, 1'b1);
    sh(BASE | 32'h370, 32'h44, 32'h9800_0000, 1'b1);
    sh(32'h03a0_14ab, 0, 32'hab00_0000, 1'b1);
    // pc as the second operand: 8 ahead with encoded shift, 12 with register shift
    ex(32'h01a0_100f, MV, 0);
    rc("pc as operand", shift_psr_pkg::ADDR_OPERAND2, 32'h1008);
    ex(32'h01a0_101f, MV, 0);
    rc("pc as operand", shift_psr_pkg::ADDR_OPERAND2, 32'h100c);
    ex(BASE | 32'h390, MV, 32'h4);
    acc(1'b0, shift_psr_pkg::ADDR_INFO, 32'h0);
    chk("undefined", q & 32'hfe, 32'h2);
    // logical op with flag set: N, Z and shifter carry land in the word
    wc(32'h0000_00d3);
    acc(1'b1, shift_psr_pkg::ADDR_RESULT, 32'h0);
    ex(BASE | 32'h0010_0020, MV, 0);
    cur(32'h6000_00d3);
    acc(1'b1, shift_psr_pkg::ADDR_RESULT, 32'h200);
    ex(32'h01a0_f002, MV, 0);
    rc("pc", shift_psr_pkg::ADDR_PC, 32'h200);
    cur(32'h6000_00d3);
    acc(1'b0, shift_psr_pkg::ADDR_INFO, 32'h0);
    chk("pc cost", q & 32'hfc, 32'ha4);
    acc(1'b1, shift_psr_pkg::ADDR_SAVED, 32'h9000_0012);
    acc(1'b1, shift_psr_pkg::ADDR_RESULT, 32'h300);
    ex(32'h01b0_f002, MV, 0);
    rc("pc", shift_psr_pkg::ADDR_PC, 32'h300);
    cur(32'h9000_0012);
    sv(32'h0);
    acc(1'b1, shift_psr_pkg::ADDR_SAVED, 32'h4000_00d3);
    wc(32'h0000_00d3);
    sv(32'h9000_0012);
    ex(32'h0130_f002, MV, 0);
    cur(32'h9000_0012);
    ex(32'h0130_f002, MV, 0);
    cur(32'h4000_00d3);
    wc(32'h0000_0010);
    ex(32'h0130_f002, MV, 0);
    cur(32'h0000_0010);
    // user mode: whole-word write may only reach the flags
    ex(32'h0121_f002, 32'ha000_00d3, 0);
    cur(32'ha000_0010);
    acc(1'b0, shift_psr_pkg::ADDR_INFO, 32'h0);
    chk("move", q & 32'h08, 32'h08);
    wc(32'h0000_00d3);
    ex(32'h0120_f002, 32'h5fff_ff1f, 0);
    cur(32'h5000_00d3);
    ex(32'h0360_f4f0, MV, 0);
    sv(32'hf000_0012);
    ex(32'h010f_1000, MV, 0);
    rc("move out", shift_psr_pkg::ADDR_MOVE_OUT, 32'h5000_00d3);
    ex(32'h014f_1000, MV, 0);
    rc("move out", shift_psr_pkg::ADDR_MOVE_OUT, 32'hf000_0012);
    ex(32'h0121_f002, 32'h1000_0011, 0);
    cur(32'h1000_0011);
    end_of_test();
  end
endmodule
`default_nettype wire
